// ---- shared/pmw_consts.svh ----
// offsets, field positions, reset values and timing counts of the power-mode controller
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH

`define PMW_CLK_PERIOD_NS 10
`define PMW_PLL_LOCK_US   150
`define PMW_PLL_LOCK_CYC  ((`PMW_PLL_LOCK_US * 1000 + `PMW_CLK_PERIOD_NS - 1) / `PMW_CLK_PERIOD_NS)
`define PMW_WAKE_RST_CYC  65535
`define PMW_BOOT_BYTES    4096
`define PMW_BOOT_WORDS    (`PMW_BOOT_BYTES / 4)

`define PMW_OFF_CLK_GATE  8'h00
`define PMW_OFF_SLOW      8'h04
`define PMW_OFF_WAKE      8'h08
`define PMW_OFF_SCR_A     8'h0c
`define PMW_OFF_SCR_B     8'h10
`define PMW_OFF_EXT_MASK  8'h14
`define PMW_OFF_SRC_PND   8'h18
`define PMW_OFF_EXT_PND   8'h1c
`define PMW_OFF_MISC      8'h20
`define PMW_OFF_WAKE_EN   8'h24
`define PMW_OFF_TRIG_LO   8'h28
`define PMW_OFF_TRIG_HI   8'h2c
`define PMW_OFF_STATUS    8'h30

`define PMW_CG_IDLE_BIT   2
`define PMW_CG_OFF_BIT    3
`define PMW_SLOW_SEL_BIT  4
`define PMW_SLOW_PLL_BIT  5
`define PMW_WAKE_BIT      2
`define PMW_SRC_BATT_BIT  7
`define PMW_PROT_ON       3'h7

`define PMW_TRIG_LOW      3'h0
`define PMW_TRIG_HIGH     3'h1
`define PMW_TRIG_FALL     3'h2
`define PMW_TRIG_RISE     3'h3
`define PMW_TRIG_BOTH     3'h4

`define PMW_MISC_RST      20'h0_0000
`define PMW_PWR_RST '{core_power_en: 1'b1, core_reset_n: 1'b0, pll_en: 1'b1, \
  fast_clk_sel: 1'b1, data_pullup: 2'h0, default: 1'b0}

`endif

// ---- shared/pmw_pkg.sv ----
// types shared by the power-mode controller
package pmw_pkg;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pmw_bus_t;

  typedef struct packed {
    logic       core_power_en;
    logic       core_reset_n;
    logic       cpu_idle_req;
    logic       cpu_clk_stop;
    logic       pad_hold;
    logic       pll_en;
    logic       fast_clk_sel;
    logic       sdram_protect;
    logic       usb_suspend;
    logic       data_bus_float;
    logic [1:0] data_pullup;
  } pmw_pwr_t;

  typedef enum logic [2:0] {PMW_NORMAL, PMW_IDLE_REQ, PMW_IDLE, PMW_OFF, PMW_WAKE_RST} pmw_mode_t;
  typedef enum logic [1:0] {PMW_B_IDLE, PMW_B_REQ, PMW_B_WAIT, PMW_B_DONE} pmw_boot_st_t;
endpackage

// ---- hw/pmw_wake_detect.sv ----
// synchronised wake-pin trigger detection
`timescale 1ns/1ns
`default_nettype none
`include "pmw_consts.svh"
module pmw_wake_detect import pmw_pkg::*; #(
  parameter int N = 16
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic [N-1:0]   pin_raw,
  input  wire logic           batt_raw,
  input  wire logic [3*N-1:0] trig,
  input  wire logic [N-1:0]   en,
  output logic      [N-1:0]   evt,
  output logic                batt_ok
);
  logic [N:0]   sync_a;
  logic [N:0]   sync_b;
  logic [N-1:0] prev;
  logic [N-1:0] next_evt;

  function automatic logic trig_hit(input logic [2:0] m, input logic cur, input logic old);
    case (m)
      `PMW_TRIG_LOW:  return !cur;
      `PMW_TRIG_HIGH: return cur;
      `PMW_TRIG_FALL: return old & !cur;
      `PMW_TRIG_RISE: return !old & cur;
      `PMW_TRIG_BOTH: return old ^ cur;
      default:        return 1'b0;
    endcase
  endfunction

  for (genvar i = 0; i < N; i++) begin : g_pin
    assign next_evt[i] = en[i] & trig_hit(trig[3*i +: 3], sync_b[i], prev[i]);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a  <= '0;
      sync_b  <= '0;
      prev    <= '0;
      evt     <= '0;
      batt_ok <= 1'b0;
    end else begin
      sync_a  <= {batt_raw, pin_raw};
      sync_b  <= sync_a;
      prev    <= sync_b[N-1:0];
      evt     <= next_evt;
      batt_ok <= sync_b[N];
    end
  end

  property p_en_gate;
    @(posedge clk) disable iff (!rst_n) (en == '0) |=> (evt == '0);
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("event on unconfigured pin");
endmodule
`default_nettype wire

// ---- hw/pmw_boot_copy.sv ----
// boot-block copy from flash into boot buffer
`timescale 1ns/1ns
`default_nettype none
`include "pmw_consts.svh"
module pmw_boot_copy import pmw_pkg::*; #(
  parameter int WORDS = `PMW_BOOT_WORDS,
  parameter int AW    = 10
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          start,
  output logic               nand_req,
  output logic [AW-1:0]      nand_addr,
  input  wire logic [31:0]   nand_data,
  input  wire logic          nand_valid,
  output logic               sram_we,
  output logic [AW-1:0]      sram_addr,
  output logic [31:0]        sram_wdata,
  output logic               done
);
  pmw_boot_st_t st, next_st;
  logic [AW-1:0] widx, next_widx, next_nand_addr, next_sram_addr;
  logic          next_nand_req, next_sram_we, next_done;
  logic [31:0]   next_sram_wdata;

  always_comb begin
    next_st         = st;
    next_widx       = widx;
    next_nand_req   = 1'b0;
    next_nand_addr  = nand_addr;
    next_sram_we    = 1'b0;
    next_sram_addr  = sram_addr;
    next_sram_wdata = sram_wdata;
    next_done       = done;
    if (start) begin
      next_st   = PMW_B_REQ;
      next_widx = '0;
      next_done = 1'b0;
    end else begin
      case (st)
        PMW_B_REQ: begin
          next_nand_req  = 1'b1;
          next_nand_addr = widx;
          next_st        = PMW_B_WAIT;
        end
        PMW_B_WAIT: if (nand_valid) begin
          next_sram_we    = 1'b1;
          next_sram_addr  = widx;
          next_sram_wdata = nand_data;
          if (widx == AW'(WORDS - 1)) begin
            next_st   = PMW_B_DONE;
            next_done = 1'b1;
          end else begin
            next_widx = widx + 1'b1;
            next_st   = PMW_B_REQ;
          end
        end
        default: next_st = st;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= PMW_B_IDLE;
      widx <= '0;
      nand_req <= 1'b0;
      nand_addr <= '0;
      sram_we <= 1'b0;
      sram_addr <= '0;
      sram_wdata <= 32'h0000_0000;
      done <= 1'b0;
    end else begin
      st <= next_st;
      widx <= next_widx;
      nand_req <= next_nand_req;
      nand_addr <= next_nand_addr;
      sram_we <= next_sram_we;
      sram_addr <= next_sram_addr;
      sram_wdata <= next_sram_wdata;
      done <= next_done;
    end
  end

  property p_done_cnt;
    @(posedge clk) disable iff (!rst_n) $rose(done) |-> (widx == AW'(WORDS - 1)) && sram_we;
  endproperty
  a_done_cnt: assert property (p_done_cnt) else $error("boot copy ended early");
endmodule
`default_nettype wire

// ---- hw/pmw_ctrl.sv ----
// power-mode, wake-up and boot control top
`timescale 1ns/1ns
`default_nettype none
`include "pmw_consts.svh"
module pmw_ctrl import pmw_pkg::*; #(
  parameter logic [15:0] WAKE_RST_CYCLES = 16'(`PMW_WAKE_RST_CYC),
  parameter logic [15:0] PLL_LOCK_CYCLES = 16'(`PMW_PLL_LOCK_CYC),
  parameter int          BOOT_WORDS      = `PMW_BOOT_WORDS,
  parameter int          BOOT_AW         = 10
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire pmw_bus_t           bus,
  output logic [31:0]             rdata,
  input  wire logic [15:0]        wake_pin,
  input  wire logic               battery_fault_n,
  input  wire logic               cpu_idle_ack,
  input  wire logic               irq_any,
  output var pmw_pwr_t            pwr,
  output logic [15:0]             ext_irq_req,
  output logic                    nand_req,
  output logic [BOOT_AW-1:0]      nand_addr,
  input  wire logic [31:0]        nand_data,
  input  wire logic               nand_valid,
  output logic                    sram_we,
  output logic [BOOT_AW-1:0]      sram_addr,
  output logic [31:0]             sram_wdata,
  output logic                    cpu_run
);
  pmw_mode_t   mode, next_mode;
  pmw_pwr_t    next_pwr;
  logic        idle_bit, next_idle_bit, off_bit, next_off_bit;
  logic        slow_sel, next_slow_sel, pll_off, next_pll_off;
  logic        locking, next_locking, wake_cause, next_wake_cause;
  logic        batt_seen, next_batt_seen, boot_kick, next_boot_kick;
  logic [15:0] lock_cnt, next_lock_cnt, rst_cnt, next_rst_cnt;
  logic [31:0] scr_a, next_scr_a, scr_b, next_scr_b, next_rdata;
  logic [15:0] external_wake_input_mask, next_external_wake_input_mask, ext_pnd, next_ext_pnd;
  logic [15:0] wake_en, next_wake_en, next_ext_irq_req;
  logic [7:0]  src_pnd, next_src_pnd;
  logic [19:0] misc, next_misc;
  logic [47:0] trig, next_trig;
  logic [15:0] evt;
  logic        batt_ok, wake_go, sw_wr;

  pmw_wake_detect #(.N(16)) u_wake (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_raw  (wake_pin),
    .batt_raw (battery_fault_n),
    .trig     (trig),
    .en       (wake_en),
    .evt      (evt),
    .batt_ok  (batt_ok)
  );

  pmw_boot_copy #(.WORDS(BOOT_WORDS), .AW(BOOT_AW)) u_boot (
    .clk        (clk),
    .rst_n      (rst_n),
    .start      (boot_kick),
    .nand_req   (nand_req),
    .nand_addr  (nand_addr),
    .nand_data  (nand_data),
    .nand_valid (nand_valid),
    .sram_we    (sram_we),
    .sram_addr  (sram_addr),
    .sram_wdata (sram_wdata),
    .done       (cpu_run)
  );

  assign wake_go = (mode == PMW_OFF) && (|evt) && batt_ok;
  // scratch kept: no writes in off or reset
  assign sw_wr   = bus.wr && (mode != PMW_OFF) && (mode != PMW_WAKE_RST);

  always_comb begin
    next_mode = mode;
    next_idle_bit = idle_bit;
    next_off_bit = off_bit;
    next_slow_sel = slow_sel;
    next_pll_off = pll_off;
    next_locking = locking;
    next_lock_cnt = lock_cnt;
    next_rst_cnt = rst_cnt;
    next_wake_cause = wake_cause;
    next_batt_seen = batt_seen;
    next_boot_kick = 1'b0;
    next_scr_a = scr_a;
    next_scr_b = scr_b;
    next_external_wake_input_mask = external_wake_input_mask;
    next_src_pnd = src_pnd;
    next_ext_pnd = ext_pnd;
    next_misc = misc;
    next_wake_en = wake_en;
    next_trig = trig;
    next_rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        `PMW_OFF_CLK_GATE: next_rdata = (32'(off_bit) << `PMW_CG_OFF_BIT) |
                                        (32'(idle_bit) << `PMW_CG_IDLE_BIT);
        `PMW_OFF_SLOW:     next_rdata = (32'(pll_off) << `PMW_SLOW_PLL_BIT) |
                                        (32'(slow_sel) << `PMW_SLOW_SEL_BIT);
        `PMW_OFF_WAKE:     next_rdata = 32'(wake_cause) << `PMW_WAKE_BIT;
        `PMW_OFF_SCR_A:    next_rdata = scr_a;
        `PMW_OFF_SCR_B:    next_rdata = scr_b;
        `PMW_OFF_EXT_MASK: next_rdata = 32'(external_wake_input_mask);
        `PMW_OFF_SRC_PND:  next_rdata = 32'(src_pnd);
        `PMW_OFF_EXT_PND:  next_rdata = 32'(ext_pnd);
        `PMW_OFF_MISC:     next_rdata = 32'(misc);
        `PMW_OFF_WAKE_EN:  next_rdata = 32'(wake_en);
        `PMW_OFF_TRIG_LO:  next_rdata = 32'(trig[23:0]);
        `PMW_OFF_TRIG_HI:  next_rdata = 32'(trig[47:24]);
        `PMW_OFF_STATUS:   next_rdata = 32'({cpu_run, locking, mode});
        default:           next_rdata = 32'h0000_0000;
      endcase
    end
    if (sw_wr) begin
      case (bus.addr)
        `PMW_OFF_CLK_GATE: begin
          next_idle_bit = bus.wdata[`PMW_CG_IDLE_BIT];
          next_off_bit  = bus.wdata[`PMW_CG_OFF_BIT];
        end
        `PMW_OFF_SLOW: begin
          next_slow_sel = bus.wdata[`PMW_SLOW_SEL_BIT];
          next_pll_off  = bus.wdata[`PMW_SLOW_PLL_BIT] & bus.wdata[`PMW_SLOW_SEL_BIT];
        end
        `PMW_OFF_WAKE:     next_wake_cause = wake_cause & ~bus.wdata[`PMW_WAKE_BIT];
        `PMW_OFF_SCR_A:    next_scr_a = bus.wdata;
        `PMW_OFF_SCR_B:    next_scr_b = bus.wdata;
        `PMW_OFF_EXT_MASK: next_external_wake_input_mask = bus.wdata[15:0];
        `PMW_OFF_SRC_PND:  next_src_pnd = src_pnd & ~bus.wdata[7:0];
        `PMW_OFF_EXT_PND:  next_ext_pnd = ext_pnd & ~bus.wdata[15:0];
        `PMW_OFF_MISC:     next_misc = bus.wdata[19:0];
        `PMW_OFF_WAKE_EN:  next_wake_en = bus.wdata[15:0];
        `PMW_OFF_TRIG_LO:  next_trig[23:0] = bus.wdata[23:0];
        `PMW_OFF_TRIG_HI:  next_trig[47:24] = bus.wdata[23:0];
        default:           next_mode = next_mode;
      endcase
    end
    if (locking) begin
      if (lock_cnt == PLL_LOCK_CYCLES - 16'h0001) begin
        next_locking = 1'b0;
      end else begin
        next_lock_cnt = lock_cnt + 16'h0001;
      end
    end
    if (slow_sel && !next_slow_sel && pll_off) begin
      next_pll_off  = 1'b0;
      next_locking  = 1'b1;
      next_lock_cnt = 16'h0000;
    end
    case (mode)
      PMW_NORMAL: begin
        if (off_bit) begin
          next_mode = PMW_OFF;
          next_batt_seen = 1'b0;
        end else if (idle_bit) begin
          next_mode = PMW_IDLE_REQ;
        end
      end
      PMW_IDLE_REQ: if (cpu_idle_ack) next_mode = PMW_IDLE;
      PMW_IDLE: begin
        if (irq_any) begin
          next_mode = PMW_NORMAL;
          next_idle_bit = 1'b0;
        end
      end
      PMW_OFF: begin
        if (!batt_ok) next_batt_seen = 1'b1;
        if (wake_go) begin
          next_mode = PMW_WAKE_RST;
          next_rst_cnt = 16'h0000;
          next_wake_cause = 1'b1;
          next_off_bit = 1'b0;
          next_idle_bit = 1'b0;
          next_src_pnd[3:0] = src_pnd[3:0] | (evt[3:0] & ~external_wake_input_mask[3:0]);
          next_ext_pnd[15:4] = ext_pnd[15:4] | (evt[15:4] & ~external_wake_input_mask[15:4]);
          next_src_pnd[`PMW_SRC_BATT_BIT] = src_pnd[`PMW_SRC_BATT_BIT] | batt_seen;
          next_batt_seen = 1'b0;
        end
      end
      PMW_WAKE_RST: begin
        if (rst_cnt == WAKE_RST_CYCLES - 16'h0001) begin
          next_mode = PMW_NORMAL;
          next_boot_kick = 1'b1;
        end else begin
          next_rst_cnt = rst_cnt + 16'h0001;
        end
      end
      default: next_mode = PMW_NORMAL;
    endcase
    next_ext_irq_req = (next_mode == PMW_OFF || next_mode == PMW_WAKE_RST) ? 16'h0000 : evt;
    next_pwr.core_power_en = (next_mode != PMW_OFF);
    next_pwr.core_reset_n  = (next_mode != PMW_OFF) && (next_mode != PMW_WAKE_RST);
    next_pwr.cpu_idle_req  = (next_mode == PMW_IDLE_REQ);
    next_pwr.cpu_clk_stop  = (next_mode == PMW_IDLE);
    next_pwr.pad_hold      = (next_mode == PMW_OFF);
    next_pwr.pll_en        = !next_pll_off;
    next_pwr.fast_clk_sel  = !next_slow_sel && !next_locking;
    next_pwr.sdram_protect = (next_misc[19:17] == `PMW_PROT_ON);
    next_pwr.usb_suspend   = &next_misc[13:12];
    next_pwr.data_bus_float = (next_mode == PMW_OFF);
    next_pwr.data_pullup   = next_misc[1:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= PMW_NORMAL;
      idle_bit <= 1'b0;
      off_bit <= 1'b0;
      slow_sel <= 1'b0;
      pll_off <= 1'b0;
      locking <= 1'b0;
      lock_cnt <= 16'h0000;
      rst_cnt <= 16'h0000;
      wake_cause <= 1'b0;
      batt_seen <= 1'b0;
      boot_kick <= 1'b1;
      scr_a <= 32'h0000_0000;
      scr_b <= 32'h0000_0000;
      external_wake_input_mask <= 16'hffff;
      src_pnd <= 8'h00;
      ext_pnd <= 16'h0000;
      misc <= `PMW_MISC_RST;
      wake_en <= 16'h0000;
      trig <= 48'h0000_0000_0000;
      rdata <= 32'h0000_0000;
      ext_irq_req <= 16'h0000;
      pwr <= `PMW_PWR_RST;
    end else begin
      mode <= next_mode;
      idle_bit <= next_idle_bit;
      off_bit <= next_off_bit;
      slow_sel <= next_slow_sel;
      pll_off <= next_pll_off;
      locking <= next_locking;
      lock_cnt <= next_lock_cnt;
      rst_cnt <= next_rst_cnt;
      wake_cause <= next_wake_cause;
      batt_seen <= next_batt_seen;
      boot_kick <= next_boot_kick;
      scr_a <= next_scr_a;
      scr_b <= next_scr_b;
      external_wake_input_mask <= next_external_wake_input_mask;
      src_pnd <= next_src_pnd;
      ext_pnd <= next_ext_pnd;
      misc <= next_misc;
      wake_en <= next_wake_en;
      trig <= next_trig;
      rdata <= next_rdata;
      ext_irq_req <= next_ext_irq_req;
      pwr <= next_pwr;
    end
  end

  property p_off_power;
    @(posedge clk) disable iff (!rst_n) (mode == PMW_OFF) |-> !pwr.core_power_en;
  endproperty
  a_off_power: assert property (p_off_power) else $error("core powered in off");
  property p_wake_rst;
    @(posedge clk) disable iff (!rst_n)
      (mode == PMW_WAKE_RST && rst_cnt == WAKE_RST_CYCLES - 16'h0001) |->
      !pwr.core_reset_n ##1 (mode == PMW_NORMAL && pwr.core_reset_n);
  endproperty
  a_wake_rst: assert property (p_wake_rst) else $error("wake reset length wrong");
  property p_wake_cause;
    @(posedge clk) disable iff (!rst_n) wake_go |=> wake_cause && (mode == PMW_WAKE_RST);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake cause not set");
  property p_scratch;
    @(posedge clk) disable iff (!rst_n) (mode == PMW_OFF) |=> $stable(scr_a) && $stable(scr_b);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch lost in off");
  property p_mask;
    @(posedge clk) disable iff (!rst_n) wake_go |=>
      ({ext_pnd[15:4],src_pnd[3:0]} & $past(~{ext_pnd[15:4],src_pnd[3:0]} & external_wake_input_mask)) == 16'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("masked source pended");
  property p_hi_ext;
    @(posedge clk) disable iff (!rst_n)
      (wake_go && evt[5] && !external_wake_input_mask[5]) |=> ext_pnd[5] && (src_pnd[6:4] == $past(src_pnd[6:4]));
  endproperty
  a_hi_ext: assert property (p_hi_ext) else $error("high input pended wrongly");
  property p_batt;
    @(posedge clk) disable iff (!rst_n) (mode == PMW_OFF && !batt_ok) |=> (mode == PMW_OFF);
  endproperty
  a_batt: assert property (p_batt) else $error("woke with battery fault");
  property p_idle;
    @(posedge clk) disable iff (!rst_n)
      (mode == PMW_IDLE_REQ && !cpu_idle_ack) |=> (mode == PMW_IDLE_REQ) && !pwr.cpu_clk_stop;
  endproperty
  a_idle: assert property (p_idle) else $error("idle without acknowledge");
  property p_lock;
    @(posedge clk) disable iff (!rst_n) locking |-> !pwr.fast_clk_sel && pwr.pll_en;
  endproperty
  a_lock: assert property (p_lock) else $error("fast clock during lock");
  property p_hold;
    @(posedge clk) disable iff (!rst_n) (mode == PMW_OFF) |-> pwr.pad_hold && pwr.data_bus_float;
  endproperty
  a_hold: assert property (p_hold) else $error("pins not held in off");
endmodule
`default_nettype wire

// ---- verification/pmw_far_model.sv ----
// flash and processor-wrapper responder for the power-mode controller
`timescale 1ns/1ns
`default_nettype none
module pmw_far_model #(
  parameter int LAT = 2
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       nand_req,
  input  wire logic [9:0] nand_addr,
  output logic [31:0]     nand_data,
  output logic            nand_valid,
  input  wire logic       idle_req,
  output logic            idle_ack
);
  logic [LAT-1:0] pipe;
  logic [9:0]     a;
  logic [2:0]     n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe <= '0;
      a <= '0;
      n <= '0;
      nand_data <= 32'h0000_0000;
      nand_valid <= 1'b0;
      idle_ack <= 1'b0;
    end else begin
      if (nand_req) a <= nand_addr;
      pipe <= {pipe[LAT-2:0], nand_req};
      nand_valid <= pipe[LAT-1];
      // flash word holds a known pattern
      nand_data <= pipe[LAT-1] ? ({22'h0, a} ^ 32'ha5a5_0000) : ~nand_data;
      n <= idle_req ? ((n == 3'h3) ? n : n + 3'h1) : 3'h0;
      idle_ack <= idle_req && (n == 3'h3);
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench of the power-mode controller
`timescale 1ns/1ns
`default_nettype none
module tb import pmw_pkg::*;;
  logic clk = 0, rst_n = 0, batt_n = 1, ack, irq = 0, nreq, nval, swe, run;
  pmw_bus_t bus = '0;
  pmw_pwr_t pwr;
  logic [31:0] rdata, ndata, swd;
  logic [15:0] pin = '0, ext_irq;
  logic [9:0] naddr, saddr;
  int err_total = 0, n_compared = 0, cyc = 0, i;
  always #5 clk = ~clk;
  pmw_ctrl #(.WAKE_RST_CYCLES(16'h0010), .PLL_LOCK_CYCLES(16'h0014), .BOOT_WORDS(8)) DUT (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .wake_pin(pin),
    .battery_fault_n(batt_n), .cpu_idle_ack(ack), .irq_any(irq), .pwr(pwr),
    .ext_irq_req(ext_irq), .nand_req(nreq), .nand_addr(naddr), .nand_data(ndata),
    .nand_valid(nval), .sram_we(swe), .sram_addr(saddr), .sram_wdata(swd), .cpu_run(run));
  pmw_far_model #(.LAT(2)) far (.clk(clk), .rst_n(rst_n), .nand_req(nreq),
    .nand_addr(naddr), .nand_data(ndata), .nand_valid(nval),
    .idle_req(pwr.cpu_idle_req), .idle_ack(ack));
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic wait_run();
    for (i = 0; i < 300 && run !== 1'b1; i++) @(posedge clk);
    #1 chk(run, 1'b1);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      finish_test();
    end
    if (rst_n && swe === 1'b1) chk(swd, {22'h0, saddr} ^ 32'ha5a5_0000);
  end
  task automatic t_regs();
    wr(8'h0c, 32'h1234_5678);
    wr(8'h10, 32'hcafe_0001);
    rd(8'h0c, 32'hffff_ffff, 32'h1234_5678);
    rd(8'h34, 32'hffff_ffff, 32'h0000_0000);
    rd(8'h14, 32'hffff_ffff, 32'h0000_ffff);
    rd(8'h30, 32'h0000_0010, 32'h0000_0010);
  endtask
  task automatic t_idle();
    wr(8'h00, 32'h0000_0004);
    for (i = 0; i < 40 && pwr.cpu_clk_stop !== 1'b1; i++) @(posedge clk);
    chk(i >= 4 && pwr.cpu_clk_stop === 1'b1, 1'b1);
    rd(8'h30, 32'h0000_0007, 32'h0000_0002);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    rd(8'h30, 32'h0000_0007, 32'h0000_0000);
    rd(8'h00, 32'h0000_0004, 32'h0000_0000);
  endtask
  task automatic t_slow();
    wr(8'h04, 32'h0000_0030);
    repeat (2) @(posedge clk);
    #1 chk({pwr.pll_en, pwr.fast_clk_sel}, 2'b00);
    wr(8'h04, 32'h0000_0000);
    for (i = 0; i < 100 && pwr.fast_clk_sel !== 1'b1; i++) begin
      @(posedge clk);
      #1 if (i == 1) chk({pwr.pll_en, pwr.fast_clk_sel}, 2'b10);
    end
    chk(i >= 19 && i <= 22, 1'b1);
  endtask
  task automatic t_off();
    wr(8'h24, 32'h0000_0033);
    wr(8'h28, 32'h0001_b01b);
    wr(8'h14, 32'h0000_ffde);
    wr(8'h0c, 32'h0000_0100);
    wr(8'h20, 32'h000e_3003);
    batt_n <= 1'b0;
    wr(8'h00, 32'h0000_0008);
    repeat (3) @(posedge clk);
    #1 chk({pwr.core_power_en, pwr.pad_hold, pwr.data_bus_float}, 3'b011);
    chk({pwr.data_pullup, pwr.usb_suspend, pwr.sdram_protect}, 4'hf);
    pin <= 16'h0002;
    repeat (12) @(posedge clk);
    #1 chk(pwr.core_power_en, 1'b0);
    batt_n <= 1'b1;
    repeat (5) @(posedge clk);
    pin <= 16'h0033;
    for (i = 0; i < 100 && pwr.core_reset_n !== 1'b1; i++) @(posedge clk);
    chk(i >= 19 && i <= 23, 1'b1);
    @(posedge clk);
    #1 chk(run, 1'b0);
    wait_run();
    rd(8'h08, 32'h0000_0004, 32'h0000_0004);
    rd(8'h18, 32'h0000_008f, 32'h0000_0081);
    rd(8'h1c, 32'h0000_fff0, 32'h0000_0020);
    rd(8'h0c, 32'hffff_ffff, 32'h0000_0100);
    wr(8'h20, 32'h0000_0000);
    @(posedge clk);
    #1 chk(pwr.sdram_protect, 1'b0);
    pin <= 16'h0032;
    repeat (6) @(posedge clk);
    pin <= 16'h0033;
    for (i = 0; i < 10 && ext_irq[0] !== 1'b1; i++) @(posedge clk);
    chk(ext_irq[0] === 1'b1 && pwr.core_power_en === 1'b1, 1'b1);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wait_run();
    t_regs();
    t_idle();
    t_slow();
    t_off();
    finish_test();
  end
endmodule
`default_nettype wire
